// [adcsq_defs.svh]
/*
  register offsets, field positions, reset values and timing counts for the
  software-trigger converter sequencer. assumes inclusion by bare name.
*/
`ifndef ADCSQ_DEFS_SVH
`define ADCSQ_DEFS_SVH

`define ADCSQ_OFF_MODE 12'h000
`define ADCSQ_OFF_CHSEL 12'h004
`define ADCSQ_OFF_WORD 12'h008
`define ADCSQ_OFF_BYTE 12'h00c
`define ADCSQ_OFF_RANGE 12'h010
`define ADCSQ_OFF_UPPER 12'h014
`define ADCSQ_OFF_LOWER 12'h018
`define ADCSQ_OFF_STATUS 12'h01c

`define ADCSQ_BIT_RUN 7
`define ADCSQ_BIT_SCAN 6
`define ADCSQ_BIT_ONESHOT 5
`define ADCSQ_BIT_POWER 0
`define ADCSQ_BIT_RCK 0
`define ADCSQ_BIT_RCK_INSIDE 1
`define ADCSQ_BIT_TRIG 4

`define ADCSQ_SAR_W 10
`define ADCSQ_CH_W 3
`define ADCSQ_WORD_SHIFT 6
`define ADCSQ_CONV_CYCLES 8'h18
`define ADCSQ_RST_WORD 16'h0000
`define ADCSQ_RST_BYTE 8'h00
`define ADCSQ_RST_UPPER 8'hff
`define ADCSQ_RST_LOWER 8'h00

`endif

// [adcsq_pkg.sv]
/*
  types shared by the sequencer modules. assumes adcsq_defs.svh alongside.
*/
package adcsq_pkg;
  typedef enum logic [1:0] {
    ADCSQ_STOP,
    ADCSQ_STANDBY,
    ADCSQ_CONVERT
  } adcsq_state_e;
endpackage

// [adcsq_sar_engine.sv]
/*
  successive-approximation engine: on i_start it clears and walks the
  approximation bits msb first against i_cmp_hi, one bit per clock.
  assumes i_cmp_hi comes from the analog comparator on this clock,
  already resolved for the tap on o_tap.
*/
`timescale 1ns/10ps
`include "adcsq_defs.svh"
module adcsq_sar_engine #(
  parameter int SAR_W = `ADCSQ_SAR_W
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic i_cmp_hi,
  output logic [SAR_W-1:0] o_tap,
  output logic [SAR_W-1:0] o_result,
  output logic o_busy,
  output logic o_done
);
  logic [SAR_W-1:0] approx_reg;
  logic [SAR_W-1:0] bit_reg;
  logic busy_reg;
  logic done_reg;
  wire last_bit = bit_reg[0];
  wire [SAR_W-1:0] kept = i_cmp_hi ? approx_reg : (approx_reg & ~bit_reg);

  assign o_tap = approx_reg;
  assign o_result = approx_reg;
  assign o_busy = busy_reg;
  assign o_done = done_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      approx_reg <= '0;
      bit_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (i_start) begin
        approx_reg <= {1'b1, {(SAR_W-1){1'b0}}};
        bit_reg <= {1'b1, {(SAR_W-1){1'b0}}};
        busy_reg <= 1'b1;
      end else if (i_abort) begin
        busy_reg <= 1'b0;
      end else if (busy_reg) begin
        approx_reg <= kept | (bit_reg >> 1);
        bit_reg <= bit_reg >> 1;
        if (last_bit) begin
          approx_reg <= kept;
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end
endmodule

// [adcsq_top.sv]
/*
  software-trigger conversion sequencer with apb register slave, select and
  scan modes, sequential or one-shot, range check and result registers.
  assumes one 20 mhz clock, apb master on that clock, and a comparator
  input resolved each clock for the tap value driven out.
*/
// Implementation choices: the placing of the registers and the APB slave port.
// Behaviour
// - select mode: run starts converting the channel in channel select.
// - each finished conversion loads word and byte results and pulses done irq.
// - select sequential: same channel reconverts at once until run cleared.
// - select one-shot: after one conversion run clears, back to standby.
// - scan mode: run converts group slots first through fourth in order.
// - scan mode: result and done irq after each channel, four per pass.
// - scan sequential: after fourth slot restart pass at first slot.
// - scan one-shot: after four slots run clears, back to standby.
// - writing run 1 mid-conversion restarts: same channel, or group start.
// - channel select write mid-conversion aborts, restarts on new selection.
// - clearing run mid-conversion aborts to standby with no result stored.
// - clearing power bit in standby puts converter in stopped state.
// - while power is 0, run writes of 1 are ignored.
// - hardware trigger never starts or restarts a conversion.
// - range check on and result outside the limits with inside set, or within them with inside clear: no store, no irq.
// - word result is 16 bits, 10-bit value times sixty-four.
// - byte result is 8 bits, an 8-bit form of each result.
// - reset clears word and byte results to zero.
`timescale 1ns/10ps
`include "adcsq_defs.svh"
module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int CONV_CYCLES = `ADCSQ_CONV_CYCLES,
  parameter int CH_W = `ADCSQ_CH_W
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_cmp_hi,
  input wire logic i_hw_trigger,
  output logic [`ADCSQ_SAR_W-1:0] o_tap,
  output logic [CH_W-1:0] o_channel,
  output logic o_sample,
  output logic o_converter_power,
  output logic o_conversion_done_irq
);
  localparam int SAR_W = `ADCSQ_SAR_W;
  localparam logic [7:0] CONV_LEN = 8'(CONV_CYCLES);

  adcsq_state_e state_reg;
  adcsq_state_e state_next;
  logic converter_power_bit_reg;
  logic conversion_run_bit_reg;
  logic scan_mode_reg;
  logic oneshot_reg;
  logic [CH_W-1:0] channel_select_register_reg;
  logic range_check_select_reg;
  logic range_inside_reg;
  logic [7:0] upper_limit_register_reg;
  logic [7:0] lower_limit_register_reg;
  logic [15:0] result_word_register_reg;
  logic [7:0] result_byte_register_reg;
  logic [1:0] slot_reg;
  logic [1:0] slot_next;
  logic [7:0] wait_reg;
  logic irq_reg;
  logic cmp_meta_reg;
  logic cmp_sync_reg;
  logic trig_meta_reg;
  logic trig_sync_reg;
  logic [31:0] prdata_reg;

  // apb decode
  wire wr_en = i_psel & i_penable & i_pwrite;
  wire rd_en = i_psel & i_penable & ~i_pwrite;
  wire hit_mode = i_paddr == `ADCSQ_OFF_MODE;
  wire hit_chsel = i_paddr == `ADCSQ_OFF_CHSEL;
  wire hit_word = i_paddr == `ADCSQ_OFF_WORD;
  wire hit_byte = i_paddr == `ADCSQ_OFF_BYTE;
  wire hit_range = i_paddr == `ADCSQ_OFF_RANGE;
  wire hit_upper = i_paddr == `ADCSQ_OFF_UPPER;
  wire hit_lower = i_paddr == `ADCSQ_OFF_LOWER;
  wire hit_status = i_paddr == `ADCSQ_OFF_STATUS;
  wire mapped = hit_mode | hit_chsel | hit_word | hit_byte | hit_range | hit_upper
    | hit_lower | hit_status;
  wire wr_mode = wr_en & hit_mode;
  wire wr_chsel = wr_en & hit_chsel;
  wire wr_range = wr_en & hit_range;
  wire wr_upper = wr_en & hit_upper;
  wire wr_lower = wr_en & hit_lower;
  wire wd_run = i_pwdata[`ADCSQ_BIT_RUN];
  wire wd_power = i_pwdata[`ADCSQ_BIT_POWER];

  // sequencer control
  wire converting = state_reg == ADCSQ_CONVERT;
  wire run_set = wr_mode & wd_run & wd_power & converter_power_bit_reg;
  wire run_clear = wr_mode & ~(wd_run & wd_power);
  wire restart = converting & (run_set | wr_chsel) & ~run_clear;
  wire start_fresh = (state_reg == ADCSQ_STANDBY) & run_set;
  wire sample_done = converting & (wait_reg == 8'h00);

  logic eng_start;
  logic eng_done;
  logic eng_busy;
  logic [SAR_W-1:0] eng_result;

  // range check on upper eight result bits
  wire [7:0] res_hi = eng_result[SAR_W-1 -: 8];
  wire in_limits = (res_hi <= upper_limit_register_reg) & (res_hi >= lower_limit_register_reg);
  wire range_ok = ~range_check_select_reg | (in_limits == range_inside_reg);
  wire finish = converting & eng_done & ~run_clear & ~restart;
  wire store = finish & range_ok;
  wire last_slot = ~scan_mode_reg | (slot_reg == 2'd3);
  wire stop_after = finish & oneshot_reg & last_slot;

  // only software writes abort; the trigger level is only readable
  wire eng_abort = restart | run_clear;
  // no start in a cycle that restarts or stops, so the abort always wins
  assign eng_start = sample_done & ~eng_busy & ~eng_done & ~eng_abort;

  adcsq_sar_engine #(
    .SAR_W(SAR_W)
  ) u_engine (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_start(eng_start),
    .i_abort(eng_abort),
    .i_cmp_hi(cmp_sync_reg),
    .o_tap(o_tap),
    .o_result(eng_result),
    .o_busy(eng_busy),
    .o_done(eng_done)
  );

  always_comb begin
    state_next = state_reg;
    slot_next = slot_reg;
    unique case (state_reg)
      ADCSQ_STOP: begin
        if (wr_mode & wd_power) begin
          state_next = ADCSQ_STANDBY;
        end
      end
      ADCSQ_STANDBY: begin
        if (wr_mode & ~wd_power) begin
          state_next = ADCSQ_STOP;
        end else if (start_fresh) begin
          state_next = ADCSQ_CONVERT;
          slot_next = 2'd0;
        end
      end
      ADCSQ_CONVERT: begin
        if (run_clear) begin
          state_next = ADCSQ_STANDBY;
        end else if (restart) begin
          slot_next = 2'd0;
        end else if (stop_after) begin
          state_next = ADCSQ_STANDBY;
          slot_next = 2'd0;
        end else if (finish) begin
          slot_next = scan_mode_reg ? slot_reg + 2'd1 : 2'd0;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
    end else begin
      cmp_meta_reg <= i_cmp_hi;
      cmp_sync_reg <= cmp_meta_reg;
    end
  end

  // trigger pin synchroniser, level shown in status only
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      trig_meta_reg <= 1'b0;
      trig_sync_reg <= 1'b0;
    end else begin
      trig_meta_reg <= i_hw_trigger;
      trig_sync_reg <= trig_meta_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= ADCSQ_STOP;
    end else begin
      state_reg <= state_next;
    end
  end

  // scan slot, zeroed at start, restart and one-shot stop, but a run clear leaves it as it was
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      slot_reg <= 2'd0;
    end else begin
      slot_reg <= slot_next;
    end
  end

  // sample interval counter, reloaded at every start or restart
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_reg <= CONV_LEN;
    end else if (start_fresh | restart | finish | ~converting) begin
      wait_reg <= CONV_LEN;
    end else if (wait_reg != 8'h00) begin
      wait_reg <= wait_reg - 8'h01;
    end
  end

  // mode register: power bit
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      converter_power_bit_reg <= 1'b0;
    end else if (wr_mode) begin
      converter_power_bit_reg <= wd_power;
    end
  end

  // run bit: refused without power, cleared after a one-shot
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      conversion_run_bit_reg <= 1'b0;
    end else if (wr_mode) begin
      conversion_run_bit_reg <= wd_run & wd_power & converter_power_bit_reg;
    end else if (stop_after) begin
      conversion_run_bit_reg <= 1'b0;
    end
  end

  // scan and one-shot selection
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scan_mode_reg <= 1'b0;
      oneshot_reg <= 1'b0;
    end else if (wr_mode) begin
      scan_mode_reg <= i_pwdata[`ADCSQ_BIT_SCAN];
      oneshot_reg <= i_pwdata[`ADCSQ_BIT_ONESHOT];
    end
  end

  // channel select, a write mid-conversion also restarts
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      channel_select_register_reg <= '0;
    end else if (wr_chsel) begin
      channel_select_register_reg <= i_pwdata[CH_W-1:0];
    end
  end

  // range check selection
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      range_check_select_reg <= 1'b0;
      range_inside_reg <= 1'b1;
    end else if (wr_range) begin
      range_check_select_reg <= i_pwdata[`ADCSQ_BIT_RCK];
      range_inside_reg <= i_pwdata[`ADCSQ_BIT_RCK_INSIDE];
    end
  end

  // limits, compared with the upper eight result bits
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      upper_limit_register_reg <= `ADCSQ_RST_UPPER;
    end else if (wr_upper) begin
      upper_limit_register_reg <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lower_limit_register_reg <= `ADCSQ_RST_LOWER;
    end else if (wr_lower) begin
      lower_limit_register_reg <= i_pwdata[7:0];
    end
  end

  // result registers, word and byte
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      result_word_register_reg <= `ADCSQ_RST_WORD;
      result_byte_register_reg <= `ADCSQ_RST_BYTE;
    end else if (store) begin
      result_word_register_reg <= {eng_result, {`ADCSQ_WORD_SHIFT{1'b0}}};
      result_byte_register_reg <= res_hi;
    end
  end

  // done pulse, one cycle per stored result
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= store;
    end
  end

  // read mux
  always_comb begin
    prdata_reg = 32'h0000_0000;
    if (hit_mode) begin
      prdata_reg[`ADCSQ_BIT_RUN] = conversion_run_bit_reg;
      prdata_reg[`ADCSQ_BIT_SCAN] = scan_mode_reg;
      prdata_reg[`ADCSQ_BIT_ONESHOT] = oneshot_reg;
      prdata_reg[`ADCSQ_BIT_POWER] = converter_power_bit_reg;
    end else if (hit_chsel) begin
      prdata_reg[CH_W-1:0] = channel_select_register_reg;
    end else if (hit_word) begin
      prdata_reg[15:0] = result_word_register_reg;
    end else if (hit_byte) begin
      prdata_reg[7:0] = result_byte_register_reg;
    end else if (hit_range) begin
      prdata_reg[`ADCSQ_BIT_RCK] = range_check_select_reg;
      prdata_reg[`ADCSQ_BIT_RCK_INSIDE] = range_inside_reg;
    end else if (hit_upper) begin
      prdata_reg[7:0] = upper_limit_register_reg;
    end else if (hit_lower) begin
      prdata_reg[7:0] = lower_limit_register_reg;
    end else if (hit_status) begin
      prdata_reg[1:0] = state_reg;
      prdata_reg[3:2] = slot_reg;
      prdata_reg[`ADCSQ_BIT_TRIG] = trig_sync_reg;
    end
  end

  assign o_prdata = rd_en ? prdata_reg : 32'h0000_0000;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;
  // scan slot selects one of four channels of the group
  assign o_channel = scan_mode_reg
    ? {channel_select_register_reg[CH_W-1:2], slot_reg}
    : channel_select_register_reg;
  assign o_sample = converting & ~eng_busy & ~eng_done;
  assign o_converter_power = converter_power_bit_reg;
  assign o_conversion_done_irq = irq_reg;
endmodule

// [adcsq_monitor.sv]
/*
  concurrent checks on the sequencer top ports.
  assumes one clock, async active-low reset, bound to adcsq_top.
*/
`timescale 1ns/10ps
`include "adcsq_defs.svh"
module adcsq_monitor #(
  parameter int CONV_CYCLES = 24,
  parameter int CH_W = 3
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [CH_W-1:0] o_channel,
  input wire logic o_sample,
  input wire logic o_converter_power,
  input wire logic o_conversion_done_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  wire wr = i_psel && i_penable && i_pwrite;
  wire wr_mode = wr && (i_paddr == `ADCSQ_OFF_MODE);
  wire wr_chsel = wr && (i_paddr == `ADCSQ_OFF_CHSEL);
  wire wr_any = wr_mode || wr_chsel;
  wire irq = o_conversion_done_irq;
  wire run_go = wr_mode && i_pwdata[7] && i_pwdata[0] && o_converter_power;
  logic scan_reg;
  sequence s_quiet;
    !irq [*8];
  endsequence
  sequence s_sampling;
    o_sample ##1 o_sample;
  endsequence
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) scan_reg <= 1'b0;
    else if (wr_mode) scan_reg <= i_pwdata[6];
  end
  irq_pulse_a: assert property (irq |=> s_quiet)
    else $error("done pulse too long or too close");
  power_track_a: assert property (wr_mode |=> o_converter_power == $past(i_pwdata[0]))
    else $error("power bit not written");
  off_idle_a: assert property (!o_converter_power |-> !o_sample)
    else $error("sampling while powered down");
  run_start_a: assert property (run_go |=> s_sampling)
    else $error("run write did not start sampling");
  scan_first_a: assert property (run_go && i_pwdata[6] |=> o_channel[1:0] == 2'b00)
    else $error("scan did not start at first slot");
  chsel_select_a: assert property (
    wr_chsel && !scan_reg |=> o_channel == $past(i_pwdata[2:0]))
    else $error("select channel not applied");
  chsel_quiet_a: assert property (wr_chsel && o_sample |=> s_quiet)
    else $error("result after channel change abort");
  abort_quiet_a: assert property (wr_mode && !i_pwdata[7] && o_sample |=> s_quiet)
    else $error("result after run clear");
  hw_ignore_a: assert property ($rose(o_sample) |-> $past(wr_any) || irq || $past(irq))
    else $error("conversion started without software");
endmodule
bind adcsq_top adcsq_monitor #(.CONV_CYCLES(CONV_CYCLES), .CH_W(CH_W)) i_mon (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_channel(o_channel),
  .o_sample(o_sample), .o_converter_power(o_converter_power),
  .o_conversion_done_irq(o_conversion_done_irq));

// [adcsq_top_tb.sv]
/*
  self-checking bench: apb master, comparator level, result model.
  assumes adcsq_top and the monitor bind are compiled before it.
*/
`timescale 1ns/10ps
`include "adcsq_defs.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module adcsq_top_tb;
  localparam logic [11:0] MD = `ADCSQ_OFF_MODE;
  localparam logic [11:0] CS = `ADCSQ_OFF_CHSEL;
  localparam logic [11:0] ST = `ADCSQ_OFF_STATUS;
  logic i_clk = 0, i_resetn = 0, psel = 0, pen = 0, pwr = 0, cmp = 1, hwt = 0, prev = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, err_o, err, irq, smp, pwr_o;
  logic [2:0] ch;
  int n_fail = 0, num_checks = 0, L, c, k, g, m, qv;
  int q[$];
  always #25 i_clk = ~i_clk;
  adcsq_top #(.CONV_CYCLES(8), .CH_W(3)) i_dut (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(err_o), .i_cmp_hi(cmp),
    .i_hw_trigger(hwt), .o_tap(), .o_channel(ch), .o_sample(smp),
    .o_converter_power(pwr_o), .o_conversion_done_irq(irq));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      end_sim();
    end
    rd = prdata;
    err = err_o;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] msk = '1);
    apb(1'b0, a, 32'h0);
    `CHK(rd & msk, e)
  endtask
  task automatic res();
    rdchk(`ADCSQ_OFF_WORD, 32'(m * 64));
    rdchk(`ADCSQ_OFF_BYTE, 32'(m / 4));
  endtask
  task automatic wirq(output int n);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (irq !== 1'b1 && n < 400);
    if (irq !== 1'b1) begin
      n_fail++;
      end_sim();
    end
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge i_clk);
      `CHK(irq, 1'b0)
    end
  endtask
  // channel seen at each sampling start against the expected queue
  always @(negedge i_clk) begin
    if (smp === 1'b1 && prev === 1'b0 && q.size() > 0) begin
      qv = q.pop_front();
      `CHK(ch, 3'(qv))
    end
    prev = smp;
  end
  initial begin
    void'($urandom(32'h6151f6bb));
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    rdchk(`ADCSQ_OFF_WORD, 32'h0);
    rdchk(`ADCSQ_OFF_BYTE, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, MD, 32'h80);
    rdchk(MD, 32'h0, 32'h80);
    quiet(40);
    apb(1'b1, MD, 32'h1);
    rdchk(ST, 32'h1, 32'h3);
    repeat (20) @(posedge i_clk);
    $display("done: power up");
    g = $urandom % 8;
    apb(1'b1, CS, 32'(g));
    apb(1'b1, MD, 32'ha1);
    wirq(L);
    `CHK(ch, 3'(g))
    m = 1023;
    res();
    rdchk(MD, 32'h0, 32'h80);
    quiet(60);
    @(posedge i_clk);
    hwt <= 1'b1;
    rdchk(ST, 32'h11, 32'h13);
    hwt <= 1'b0;
    quiet(60);
    $display("done: select one-shot");
    @(posedge i_clk);
    cmp <= 1'b0;
    m = 0;
    apb(1'b1, MD, 32'h81);
    wirq(c);
    res();
    wirq(c);
    apb(1'b1, MD, 32'h81);
    wirq(c);
    `CHK(c, L)
    g = $urandom % 8;
    apb(1'b1, CS, 32'(g));
    wirq(c);
    `CHK(c, L)
    `CHK(ch, 3'(g))
    apb(1'b1, MD, 32'h1);
    quiet(60);
    res();
    rdchk(ST, 32'h1, 32'h3);
    $display("done: select sequential");
    @(posedge i_clk);
    cmp <= 1'b1;
    apb(1'b1, `ADCSQ_OFF_UPPER, 32'hfe);
    apb(1'b1, `ADCSQ_OFF_RANGE, 32'h3);
    apb(1'b1, MD, 32'ha1);
    quiet(80);
    res();
    apb(1'b1, `ADCSQ_OFF_RANGE, 32'h1);
    apb(1'b1, MD, 32'ha1);
    wirq(c);
    m = 1023;
    res();
    apb(1'b1, `ADCSQ_OFF_RANGE, 32'h2);
    $display("done: range check");
    g = $urandom % 2;
    @(posedge i_clk);
    cmp <= 1'($urandom);
    apb(1'b1, CS, 32'(g * 4));
    q = {g * 4, g * 4 + 1, g * 4 + 2, g * 4 + 3};
    apb(1'b1, MD, 32'he1);
    m = cmp ? 1023 : 0;
    repeat (4) begin
      wirq(c);
      res();
    end
    rdchk(MD, 32'h0, 32'h80);
    quiet(60);
    `CHK(q.size(), 0)
    $display("done: scan one-shot");
    q = {g * 4, g * 4 + 1, g * 4 + 2, g * 4 + 3, g * 4};
    apb(1'b1, MD, 32'hc1);
    repeat (5) wirq(c);
    `CHK(q.size(), 0)
    apb(1'b1, MD, 32'hc1);
    rdchk(ST, 32'h2, 32'hf);
    apb(1'b1, CS, 32'((1 - g) * 4));
    @(negedge i_clk);
    `CHK(ch, 3'((1 - g) * 4))
    apb(1'b1, MD, 32'h41);
    quiet(60);
    apb(1'b1, MD, 32'h0);
    rdchk(ST, 32'h0, 32'h3);
    `CHK(pwr_o, 1'b0)
    $display("done: scan sequential");
    end_sim();
  end
endmodule
